// >>> hw/starter_consts.vh
`ifndef STARTER_CONSTS_VH
`define STARTER_CONSTS_VH
// Register byte offsets
`define OFS_CTRL 8'h00
`define OFS_CMD 8'h04
`define OFS_STATUS 8'h08
`define OFS_IRQ_STAT 8'h0C
`define OFS_IRQ_MASK 8'h10
// Control register fields
`define CTRL_LEVEL_BIT 0
`define CTRL_PROF_LSB 4
`define CTRL_PROF_MSB 7
`define CTRL_SIZE_LSB 8
`define CTRL_SIZE_MSB 10
// Command register fields
`define CMD_START_STOP_BIT 0
`define CMD_EN_SET_BIT 1
`define CMD_OPERATION_ENABLE_BIT_BIT 2
`define CMD_CTL_BIT 3
// Reset values
`define CTRL_RESET 32'h0000_00B0
`define PROFILE_DEFAULT 4'hB
// Status fields
`define STAT_STATE_LSB 0
`define STAT_RUN_BIT 8
`define STAT_OP_EN_BIT 9
`define STAT_OVL_BIT 10
// Interrupt bits
`define IRQ_STATE_BIT 0
`define IRQ_OVL_BIT 1
`endif

// >>> hw/starter_control_source_fsm.v
// Summary of operation
// - Level 0 takes commands from local terminals
// - Level 1 takes commands from bus
// - Local start terminal acts as enable-set
// - Local small frames auto-enter operation
// - Local large frames use enable terminal
// - Local start terminal switching drives operation
// - Active overload forces operation enable low
// - Bus contactor profiles auto-enter operation
// - Contactor profiles follow start/stop bit changes
// - Short profiles follow enable-set bit changes
// - Long profiles follow control word bits
// - Highest priority transition wins
// - State reported, conditions from command bits
// - Both sides agree on profile selection
// - Profile eleven selected after reset
// - Overload function only in automatic position
//
// Chosen here: the AXI4-Lite slave port and the placing of the registers.
`timescale 1ns/1ps
`include "starter_consts.vh"
module starter_control_source_fsm (
   // Clock and reset
   input wire ref_clk,
   input wire reset_n,
   // AXI4-Lite write address
   input wire [7:0] s_axi_awaddr,
   input wire s_axi_awvalid,
   output wire s_axi_awready,
   // AXI4-Lite write data
   input wire [31:0] s_axi_wdata,
   input wire [3:0] s_axi_wstrb,
   input wire s_axi_wvalid,
   output wire s_axi_wready,
   // AXI4-Lite write response
   output wire [1:0] s_axi_bresp,
   output wire s_axi_bvalid,
   input wire s_axi_bready,
   // AXI4-Lite read address
   input wire [7:0] s_axi_araddr,
   input wire s_axi_arvalid,
   output wire s_axi_arready,
   // AXI4-Lite read data
   output wire [31:0] s_axi_rdata,
   output wire [1:0] s_axi_rresp,
   output wire s_axi_rvalid,
   input wire s_axi_rready,
   // Local control terminals
   input wire start_terminal,
   input wire enable_terminal,
   // Selector switch and overload sensing
   input wire [1:0] selector_pos,
   input wire overload_present,
   // Drive outputs
   output wire motor_run,
   output wire irq
);
   // Limitations of this block:
   // - The cyclic byte layouts of the field bus are not modelled; the
   //   controller writes the command bits straight into a register.
   // - Transitions are taken on levels, not on edges; a bit that is
   //   switched and switched back within one clock is not seen.
   // - All command inputs are taken as already synchronous to ref_clk.

   // Device states, one-hot; a single bit per state keeps the status
   // field readable by the controller without any decoding
   localparam [3:0] ST_INHIBIT = 4'h1; // Switch-on inhibited
   localparam [3:0] ST_READY = 4'h2; // Ready, waiting for enable-set
   localparam [3:0] pre_operation_state = 4'h4; // Armed, waiting for operation enable
   localparam [3:0] operation_state = 4'h8; // Motor commanded to run
   // Selector automatic position code; the other codes are the manual
   // on and off positions, where overload supervision is switched off
   localparam [1:0] SEL_AUTO = 2'h1;

   // Profile class helpers
   // Contactor-style profiles use only the start/stop bit
   function is_contactor;
      input [3:0] p;
      begin
         is_contactor = (p >= 4'h1) && (p <= 4'h3);
      end
   endfunction
   // Long profiles carry a full control word with the control bit
   function is_long;
      input [3:0] p;
      begin
         is_long = ((p >= 4'h7) && (p <= 4'h9)) || (p == 4'hB);
      end
   endfunction

   // Registers
   reg [31:0] ctrl_ff; // Level, profile, frame size
   reg [3:0] cmd_ff; // Command bits from bus
   reg [1:0] irq_stat_ff; // Sticky events
   reg [1:0] irq_mask_ff; // Interrupt enables
   reg [3:0] state_ff; // Device state
   reg [3:0] nxt_state;
   reg run_ff; // Motor running in operation
   reg nxt_run;
   reg ovl_prev_ff; // Overload level one cycle ago, for onset events
   // Bus handshake state
   reg aw_got_ff; // Write address held
   reg w_got_ff; // Write data held
   reg bvalid_ff; // Write response pending
   reg rvalid_ff; // Read data pending
   reg [7:0] awaddr_ff; // Latched write address
   reg [31:0] wdata_ff; // Latched write data
   reg [31:0] rdata_ff; // Read data, held until taken
   reg [3:0] wstrb_ff; // Latched byte lanes
   reg bresp_err_ff; // Write hit an unmapped word
   reg rresp_err_ff; // Read hit an unmapped word

   // Decoded configuration
   // Level 0 is local terminals, level 1 is the bus
   wire bus_mode = ctrl_ff[`CTRL_LEVEL_BIT];
   wire [3:0] profile = ctrl_ff[`CTRL_PROF_MSB:`CTRL_PROF_LSB];
   wire [2:0] frame_size = ctrl_ff[`CTRL_SIZE_MSB:`CTRL_SIZE_LSB];
   // Frame sizes 1 and 2 have no enable terminal; 0 is treated alike
   wire small_frame = (frame_size <= 3'h2);
   // Overload function only when selector in automatic
   wire ovl_active = (selector_pos == SEL_AUTO) && overload_present;

   // Effective command bits by source; each branch sets all three so
   // that no latch is inferred whatever the profile code holds
   reg en_set; // Enable-set, from terminal or bus
   reg operation_enable_bit; // Operation enable before overload override
   reg ctl_ok; // Controller has control
   always @* begin
      // Local terminals
      if (!bus_mode) begin
         en_set = start_terminal;
         operation_enable_bit = small_frame ? 1'b1 : enable_terminal;
         ctl_ok = 1'b1;
      // Contactor-style bus profiles
      end else if (is_contactor(profile)) begin
         en_set = cmd_ff[`CMD_START_STOP_BIT];
         operation_enable_bit = 1'b1;
         ctl_ok = 1'b1;
      // Long bus profiles; full control word
      end else if (is_long(profile)) begin
         en_set = cmd_ff[`CMD_EN_SET_BIT];
         operation_enable_bit = cmd_ff[`CMD_OPERATION_ENABLE_BIT_BIT];
         ctl_ok = cmd_ff[`CMD_CTL_BIT];
      // Short bus profiles, and unused codes treated as short
      end else begin
         en_set = cmd_ff[`CMD_EN_SET_BIT];
         operation_enable_bit = 1'b1;
         ctl_ok = 1'b1;
      end
   end
   // Overload overrides operation enable in every profile
   wire operation_enable_bit_eff = operation_enable_bit && !ovl_active;

   // Transition logic; checks ordered by priority, highest first.
   // Run output follows entry to and exit from the operation state, so
   // it never glitches between two states that both leave it low.
   always @* begin
      nxt_state = state_ff;
      nxt_run = run_ff;
      case (state_ff)
         ST_INHIBIT: begin
            // Wait for start released before arming
            if (ctl_ok && !en_set) nxt_state = ST_READY;
         end
         ST_READY: begin
            if (!ctl_ok) nxt_state = ST_INHIBIT;
            else if (en_set) nxt_state = pre_operation_state;
         end
         pre_operation_state: begin
            // Losing control or enable-set drops back before arming
            if (!ctl_ok || !en_set) nxt_state = ST_READY;
            else if (operation_enable_bit_eff) begin
               nxt_state = operation_state;
               nxt_run = 1'b1;
            end
         end
         operation_state: begin
            // Stop conditions outrank everything else
            if (!ctl_ok) begin
               nxt_state = ST_INHIBIT;
               nxt_run = 1'b0;
            end else if (!operation_enable_bit_eff) begin
               nxt_state = pre_operation_state;
               nxt_run = 1'b0;
            end else if (!en_set) begin
               nxt_state = ST_READY;
               nxt_run = 1'b0;
            end
         end
         // Illegal code; recover to the safest state
         default: begin
            nxt_state = ST_INHIBIT;
            nxt_run = 1'b0;
         end
      endcase
   end

   // State register; reset leaves the motor stopped and inhibited
   // Overload history resets low, matching the idle sensor level, so
   // no false onset event follows reset
   always @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         state_ff <= ST_INHIBIT;
         run_ff <= 1'b0;
         ovl_prev_ff <= 1'b0;
      end else begin
         state_ff <= nxt_state;
         run_ff <= nxt_run;
         ovl_prev_ff <= ovl_active;
      end
   end

   // Events for the interrupt block
   // State change is flagged in the cycle before the new state shows
   wire ev_state = (nxt_state != state_ff);
   // Overload onset only; a standing overload raises no further event
   wire ev_ovl = ovl_active && !ovl_prev_ff;

   // Bus handshake; one write and one read at a time.
   // Ready is combinational from flops only, never from valid, so the
   // master sees no loop through this block.
   assign s_axi_awready = !aw_got_ff && !bvalid_ff;
   assign s_axi_wready = !w_got_ff && !bvalid_ff;
   assign s_axi_arready = !rvalid_ff;
   assign s_axi_bvalid = bvalid_ff;
   assign s_axi_rvalid = rvalid_ff;
   assign s_axi_bresp = bresp_err_ff ? 2'h2 : 2'h0;
   assign s_axi_rresp = rresp_err_ff ? 2'h2 : 2'h0;
   assign s_axi_rdata = rdata_ff;
   // Both halves held and no response pending
   wire do_write = aw_got_ff && w_got_ff && !bvalid_ff;
   // Word address of the pending write; low bits ignored
   wire [7:0] wr_word = awaddr_ff & 8'hFC;
   // Write-one-to-clear request, only with the low byte lane enabled
   wire [1:0] irq_clr = (do_write && (wr_word == `OFS_IRQ_STAT) && wstrb_ff[0]) ? wdata_ff[1:0] : 2'h0;

   // Byte-lane merge; lanes without strobe keep their old value
   function [31:0] merge;
      input [31:0] old;
      input [31:0] d;
      input [3:0] s;
      integer i;
      begin
         merge = old;
         for (i = 0; i < 4; i = i + 1)
            if (s[i]) merge[i*8 +: 8] = d[i*8 +: 8];
      end
   endfunction

   // Write channel and register updates.
   // Address and data may arrive in either order; the register is
   // written one cycle after the later of the two is taken.
   always @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         aw_got_ff <= 1'b0;
         w_got_ff <= 1'b0;
         bvalid_ff <= 1'b0;
         bresp_err_ff <= 1'b0;
         awaddr_ff <= 8'h00;
         wdata_ff <= 32'h0000_0000;
         wstrb_ff <= 4'h0;
         ctrl_ff <= `CTRL_RESET;
         cmd_ff <= 4'h0;
         irq_mask_ff <= 2'h0;
         irq_stat_ff <= 2'h0;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_got_ff <= 1'b1;
            awaddr_ff <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_got_ff <= 1'b1;
            wdata_ff <= s_axi_wdata;
            wstrb_ff <= s_axi_wstrb;
         end
         // Response taken; free both channels for the next write
         if (s_axi_bvalid && s_axi_bready) bvalid_ff <= 1'b0;
         if (do_write) begin
            aw_got_ff <= 1'b0;
            w_got_ff <= 1'b0;
            bvalid_ff <= 1'b1;
            bresp_err_ff <= 1'b0;
            case (wr_word)
               // Unused control bits always read back as zero
               `OFS_CTRL: ctrl_ff <= merge(ctrl_ff, wdata_ff, wstrb_ff) & 32'h0000_07F1;
               `OFS_CMD: if (wstrb_ff[0]) cmd_ff <= wdata_ff[3:0];
               `OFS_IRQ_MASK: if (wstrb_ff[0]) irq_mask_ff <= wdata_ff[1:0];
               // Clear is applied below through irq_clr
               `OFS_IRQ_STAT: ;
               // Status is read-only; writes are accepted and ignored
               `OFS_STATUS: ;
               default: bresp_err_ff <= 1'b1;
            endcase
         end
         // Sticky events; set wins over a write-one clear in one cycle
         irq_stat_ff <= (irq_stat_ff & ~irq_clr) | {ev_ovl, ev_state};
      end
   end

   // Read channel; one cycle to answer.
   // Data is captured when the address is taken, so a state change
   // while rvalid waits for rready does not alter the answer.
   always @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         rvalid_ff <= 1'b0;
         rresp_err_ff <= 1'b0;
         rdata_ff <= 32'h0000_0000;
      end else if (s_axi_arvalid && s_axi_arready) begin
         rvalid_ff <= 1'b1;
         rresp_err_ff <= 1'b0;
         case (s_axi_araddr & 8'hFC)
            `OFS_CTRL: rdata_ff <= ctrl_ff;
            `OFS_CMD: rdata_ff <= {28'h0, cmd_ff};
            // Current state is reported back to the controller
            `OFS_STATUS: rdata_ff <= {21'h0, ovl_active, operation_enable_bit_eff, run_ff, 4'h0, state_ff};
            `OFS_IRQ_STAT: rdata_ff <= {30'h0, irq_stat_ff};
            `OFS_IRQ_MASK: rdata_ff <= {30'h0, irq_mask_ff};
            // Unmapped word reads zero with an error response
            default: begin
               rdata_ff <= 32'h0000_0000;
               rresp_err_ff <= 1'b1;
            end
         endcase
      end else if (rvalid_ff && s_axi_rready) begin
         rvalid_ff <= 1'b0;
      end
   end

   // Outputs
   // Run comes straight from a flop, so it is glitch-free
   assign motor_run = run_ff;
   // Level interrupt; stays high while any unmasked event is pending
   assign irq = |(irq_stat_ff & irq_mask_ff);
endmodule // starter_control_source_fsm

// >>> test/fieldbus_gateway_model.sv
`timescale 1ns/1ps
module fieldbus_gateway_model (
   // Clock and reset
   input wire ref_clk,
   input wire reset_n,
   // Bench requests
   input wire go,
   input wire we,
   input wire [7:0] acc_addr,
   input wire [31:0] acc_data,
   output reg acc_done,
   output reg [31:0] acc_rdata,
   output reg [1:0] acc_resp,
   // AXI4-Lite master
   output reg [7:0] s_axi_awaddr,
   output reg s_axi_awvalid,
   input wire s_axi_awready,
   output reg [31:0] s_axi_wdata,
   output reg s_axi_wvalid,
   input wire s_axi_wready,
   input wire [1:0] s_axi_bresp,
   input wire s_axi_bvalid,
   output reg s_axi_bready,
   output reg [7:0] s_axi_araddr,
   output reg s_axi_arvalid,
   input wire s_axi_arready,
   input wire [31:0] s_axi_rdata,
   input wire [1:0] s_axi_rresp,
   input wire s_axi_rvalid,
   output reg s_axi_rready
);
   // One access at a time; released lines flip so stale values never match
   always @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         {acc_done, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} <= 6'h00;
         {s_axi_awaddr, s_axi_araddr, s_axi_wdata, acc_rdata, acc_resp} <= 82'h0;
      end else begin
         acc_done <= 1'h0;
         // Address and data offered together
         if (go && we) begin
            s_axi_awaddr <= acc_addr;
            s_axi_wdata <= acc_data;
            {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
         end else if (go) begin
            s_axi_araddr <= acc_addr;
            {s_axi_arvalid, s_axi_rready} <= 2'h3;
         end
         if (s_axi_awvalid && s_axi_awready) begin
            s_axi_awvalid <= 1'h0;
            s_axi_awaddr <= ~s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            s_axi_wvalid <= 1'h0;
            s_axi_wdata <= ~s_axi_wdata;
         end
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arvalid <= 1'h0;
            s_axi_araddr <= ~s_axi_araddr;
         end
         // Answers end the access
         if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bready <= 1'h0;
            acc_done <= 1'h1;
            acc_resp <= s_axi_bresp;
         end
         if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rready <= 1'h0;
            acc_done <= 1'h1;
            acc_resp <= s_axi_rresp;
            acc_rdata <= s_axi_rdata;
         end
      end
   end
endmodule // fieldbus_gateway_model

// >>> test/starter_fsm_chk.sv
`timescale 1ns/1ps
`include "starter_consts.vh"
module starter_fsm_chk (
   // Clock and reset
   input wire ref_clk,
   input wire reset_n,
   // Write channels
   input wire [7:0] s_axi_awaddr,
   input wire s_axi_awvalid,
   input wire s_axi_awready,
   input wire [31:0] s_axi_wdata,
   input wire s_axi_wvalid,
   input wire s_axi_wready,
   // Terminals and drive
   input wire start_terminal,
   input wire enable_terminal,
   input wire [1:0] selector_pos,
   input wire overload_present,
   input wire motor_run,
   input wire irq
);
   // Shadow copies; assumes address and data arrive together
   reg [31:0] ctrl_ff;
   reg [3:0] cmd_ff;
   wire wr = s_axi_awvalid & s_axi_awready & s_axi_wvalid & s_axi_wready;
   wire loc = !ctrl_ff[0];
   wire [3:0] prof = ctrl_ff[7:4];
   wire big = ctrl_ff[10:8] > 3'h2;
   // Track mode and command words
   always @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         ctrl_ff <= `CTRL_RESET;
         cmd_ff <= 4'h0;
      end else if (wr && s_axi_awaddr == `OFS_CTRL) begin
         ctrl_ff <= s_axi_wdata;
      end else if (wr && s_axi_awaddr == `OFS_CMD) begin
         cmd_ff <= s_axi_wdata[3:0];
      end
   end
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!reset_n);
   a_overload_stops_run: assert property ((overload_present && selector_pos == 2'h1) [*4] |-> !motor_run)
      else $error("motor runs under overload");
   a_local_start_low: assert property ((loc && !start_terminal) [*4] |-> !motor_run)
      else $error("local run without start");
   a_local_enable_low: assert property ((loc && big && !enable_terminal) [*4] |-> !motor_run)
      else $error("large frame run without enable");
   a_local_small_auto: assert property ((loc && !big && !overload_present && !start_terminal) [*2] ##1
      (loc && !big && !overload_present && start_terminal) [*5] |-> motor_run)
      else $error("small frame did not reach operation");
   a_contactor_stop: assert property ((!loc && prof inside {1, 2, 3} && !cmd_ff[0]) [*4] |-> !motor_run)
      else $error("contactor profile runs without start");
   a_short_enable_set: assert property ((!loc && prof inside {4, 5, 6, 10} && !cmd_ff[1]) [*4] |-> !motor_run)
      else $error("short profile runs without enable set");
   a_long_ctl_bit: assert property ((!loc && prof inside {7, 8, 9, 11} && !cmd_ff[3]) [*4] |-> !motor_run)
      else $error("long profile runs without control bit");
   a_long_op_enable: assert property ((!loc && prof inside {7, 8, 9, 11} && !cmd_ff[2]) [*4] |-> !motor_run)
      else $error("long profile runs without operation enable");
   // Main scenarios
   c_run_rise: cover property ($rose(motor_run));
   c_irq_rise: cover property ($rose(irq));
   c_bus_run: cover property (!loc && motor_run);
endmodule // starter_fsm_chk

bind starter_control_source_fsm starter_fsm_chk starter_fsm_chk_inst (.*);

// >>> test/tb_top.sv
`timescale 1ns/1ps
`include "starter_consts.vh"
module tb_top;
   // Clock, reset, terminals
   reg ref_clk = 1'h0;
   reg reset_n = 1'h0;
   reg start_terminal, enable_terminal, overload_present, go, we;
   reg [1:0] selector_pos;
   reg [7:0] acc_addr;
   reg [31:0] acc_data;
   // Bus wires
   wire [7:0] s_axi_awaddr, s_axi_araddr;
   wire [31:0] s_axi_wdata, s_axi_rdata, acc_rdata;
   wire [1:0] s_axi_bresp, s_axi_rresp, acc_resp;
   wire [3:0] s_axi_wstrb = 4'hF;
   wire s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
   wire s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, motor_run, irq, acc_done;
   integer mismatches = 0;
   integer samples_checked = 0;
   integer p;
   starter_control_source_fsm starter_control_source_fsm_inst (.*);
   fieldbus_gateway_model fieldbus_gateway_model_inst (.*);
   always #5 ref_clk = ~ref_clk;
   task chk(input [31:0] seen, input [31:0] exp);
      begin
         samples_checked = samples_checked + 1;
         if (seen !== exp) begin
            mismatches = mismatches + 1;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
         end
      end
   endtask
   // One bus access through the gateway model, bounded wait
   task acc(input w, input [7:0] a, input [31:0] d);
      integer n;
      begin
         go <= 1'h1;
         we <= w;
         acc_addr <= a;
         acc_data <= d;
         @(posedge ref_clk);
         go <= 1'h0;
         n = 0;
         do begin
            @(posedge ref_clk);
            #1;
            n = n + 1;
         end while (acc_done !== 1'h1 && n < 50);
         if (acc_done !== 1'h1) mismatches = mismatches + 1;
         @(posedge ref_clk);
      end
   endtask
   task rd(input [7:0] a, input [31:0] m, input [31:0] e);
      begin
         acc(1'h0, a, 32'h0);
         chk(acc_rdata & m, e);
      end
   endtask
   // Drive state settles within a few cycles
   task run_is(input v);
      integer n;
      begin
         n = 0;
         #1;
         while (motor_run !== v && n < 20) begin
            @(posedge ref_clk);
            #1;
            n = n + 1;
         end
         chk({31'h0, motor_run}, {31'h0, v});
         @(posedge ref_clk);
      end
   endtask
   task report_and_stop;
      begin
         if (mismatches == 0 && samples_checked > 0) begin
            $display("SIMULATION PASSED");
         end else begin
            $display("SIMULATION FAILED");
         end
         $finish;
      end
   endtask
   initial begin
      {start_terminal, enable_terminal, overload_present, go, we} = 5'h00;
      selector_pos = 2'h1;
      acc_addr = 8'h00;
      acc_data = 32'h0;
      repeat (16) @(posedge ref_clk);
      reset_n <= 1'h1;
      @(posedge ref_clk);
      rd(`OFS_CTRL, 32'hFFFF_FFFF, `CTRL_RESET);
      rd(`OFS_STATUS, 32'h0000_000F, 32'h0000_0002);
      rd(8'h40, 32'hFFFF_FFFF, 32'h0);
      chk({30'h0, acc_resp}, 32'h2);
      acc(1'h1, `OFS_IRQ_MASK, 32'h0000_0003);
      start_terminal <= 1'h1;
      run_is(1'h1);
      rd(`OFS_STATUS, 32'h0000_010F, 32'h0000_0108);
      overload_present <= 1'h1;
      run_is(1'h0);
      rd(`OFS_IRQ_STAT, 32'h0000_0002, 32'h0000_0002);
      chk({31'h0, irq}, 32'h1);
      acc(1'h1, `OFS_IRQ_STAT, 32'h0000_0003);
      chk({31'h0, irq}, 32'h0);
      selector_pos <= 2'h2;
      run_is(1'h1);
      overload_present <= 1'h0;
      selector_pos <= 2'h1;
      start_terminal <= 1'h0;
      run_is(1'h0);
      start_terminal <= 1'h1;
      run_is(1'h1);
      acc(1'h1, `OFS_CTRL, 32'h0000_03B0);
      run_is(1'h0);
      enable_terminal <= 1'h1;
      run_is(1'h1);
      // Every profile in bus mode, terminals left active
      for (p = 1; p < 12; p = p + 1) begin
         acc(1'h1, `OFS_CMD, 32'h0);
         acc(1'h1, `OFS_CTRL, {24'h0, p[3:0], 4'h1});
         run_is(1'h0);
         acc(1'h1, `OFS_CMD, 32'h0000_0008);
         acc(1'h1, `OFS_CMD, 32'h0000_000F);
         run_is(1'h1);
         acc(1'h1, `OFS_CMD, (p < 4) ? 32'hE : (p < 7 || p == 10) ? 32'hD : 32'h7);
         run_is(1'h0);
      end
      acc(1'h1, `OFS_CMD, 32'h0000_0008);
      acc(1'h1, `OFS_CMD, 32'h0000_000F);
      run_is(1'h1);
      acc(1'h1, `OFS_CMD, 32'h0000_000B);
      run_is(1'h0);
      report_and_stop;
   end
   // Hang guard, far beyond the expected run
   initial begin
      #200000;
      mismatches = mismatches + 1;
      report_and_stop;
   end
endmodule // tb_top
